// ### design/serial_extra_lane_enable.sv
// Summary of operation
// - Bits 7..1 enable lane 1..7 link clocks
// - Bit 0 also powers extra lane serializers
// - Extra lanes follow link mode and test
// - Channel power-down keeps lanes inactive
// - Serializer n needs lanes 0..n-1 enabled
// - Link B register at 0x20B, resets zero
// - Link A register at 0x20A, resets zero
//
// Purpose: Extra-lane enable register bank for links A and B
// Assumes: Lane usage per mode is decoded outside and given as masks
// Notes:   Writes while the encoder runs are ignored; read data one cycle later
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "xlane_defines.svh"
module serial_extra_lane_enable
  import xlane_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  input  wire logic [`XL_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrStb,
  input  wire logic                  regRdStb,
  output logic      [7:0]            regRdData,
  input  wire logic                  link_encoder_enable,
  input  wire logic [`XL_MODE_W-1:0] link_mode_select,
  input  wire logic [`XL_TEST_W-1:0] link_test_pattern_select,
  input  wire logic [LANES-1:0]      modeLanesA,
  input  wire logic [LANES-1:0]      modeLanesB,
  input  wire logic [1:0]            channel_power_down,
  output logic      [LANES-1:0]      laneClockOnA,
  output logic      [LANES-1:0]      serializerOnA,
  output logic      [LANES-1:0]      laneClockOnB,
  output logic      [LANES-1:0]      serializerOnB,
  output logic      [`XL_MODE_W-1:0] extraLaneMode,
  output logic      [`XL_TEST_W-1:0] extraLaneTest,
  output logic                       writeRefused
);
  // Lane decode and register layout are written for eight lanes per link
  if (LANES != 8) begin : g_lanes_check
    $error("LANES must be 8");
  end

  logic [7:0] extra_lane_reg_link_a;
  logic [7:0] extra_lane_reg_link_b;
  logic       writeOk;
  acc_state_t accState;

  assign writeOk = regWrStb & ~link_encoder_enable;

  // Register writes, accepted only with encoder off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      extra_lane_reg_link_a <= `XL_RESET_VAL;
      extra_lane_reg_link_b <= `XL_RESET_VAL;
    end else if (clkEn && writeOk) begin
      if (regAddr == `XL_OFF_LINK_A) begin
        extra_lane_reg_link_a <= regWrData;
      end
      if (regAddr == `XL_OFF_LINK_B) begin
        extra_lane_reg_link_b <= regWrData;
      end
    end
  end

  // Read data and refusal flag, one cycle after strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData    <= 8'h00;
      writeRefused <= 1'b0;
      accState     <= ACC_IDLE;
    end else if (clkEn) begin
      writeRefused <= regWrStb & link_encoder_enable;
      case (1'b1)
        regRdStb: accState <= ACC_READ;
        regWrStb: accState <= ACC_WRITE;
        default:  accState <= ACC_IDLE;
      endcase
      if (regRdStb) begin
        case (regAddr)
          `XL_OFF_LINK_A: regRdData <= extra_lane_reg_link_a;
          `XL_OFF_LINK_B: regRdData <= extra_lane_reg_link_b;
          default:        regRdData <= 8'h00;
        endcase
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // Extra lanes share the link mode and test pattern settings
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      extraLaneMode <= '0;
      extraLaneTest <= '0;
    end else if (clkEn) begin
      extraLaneMode <= link_mode_select;
      extraLaneTest <= link_test_pattern_select;
    end
  end

  // Lane decode for link A
  lane_gate #(.LANES(LANES)) gateA (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clkEn            (clkEn),
    .regValue         (extra_lane_reg_link_a),
    .modeLanes        (modeLanesA),
    .channelPowerDown (channel_power_down[0]),
    .laneClockOn      (laneClockOnA),
    .serializerOn     (serializerOnA)
  );

  // Lane decode for link B
  lane_gate #(.LANES(LANES)) gateB (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clkEn            (clkEn),
    .regValue         (extra_lane_reg_link_b),
    .modeLanes        (modeLanesB),
    .channelPowerDown (channel_power_down[1]),
    .laneClockOn      (laneClockOnB),
    .serializerOn     (serializerOnB)
  );

  // Refused write leaves register unchanged
  a_write_refused: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && regWrStb && link_encoder_enable && regAddr == `XL_OFF_LINK_A)
      |=> $stable(extra_lane_reg_link_a))
    else $error("register changed while encoder enabled");

  // Accepted write lands
  a_write_link_b: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && writeOk && regAddr == `XL_OFF_LINK_B)
      |=> extra_lane_reg_link_b == $past(regWrData))
    else $error("link B write not stored");

  a_write_link_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && writeOk && regAddr == `XL_OFF_LINK_A)
      |=> extra_lane_reg_link_a == $past(regWrData))
    else $error("link A write not stored");

  // Power-down blocks every lane one cycle on
  sequence s_pd_hold;
    channel_power_down[0] && clkEn;
  endsequence
  a_power_down_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_pd_hold |=> (laneClockOnA == '0 && serializerOnA == '0))
    else $error("lane active on powered-down link A");

  // Extra clock enable follows register bit
  a_lane_clock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !channel_power_down[0] && extra_lane_reg_link_a[3])
      |=> laneClockOnA[3])
    else $error("extra lane clock missing");

  // Serializer requires ser bit or mode lane
  a_ser_needs_bit: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !extra_lane_reg_link_b[`XL_SER_BIT])
      |=> ((serializerOnB & ~$past(modeLanesB)) == '0))
    else $error("serializer on without enable bit");

  // Contiguity of serializer enables
  a_ser_contig: assert property (@(posedge clk) disable iff (sys_rst)
    serializerOnA[5] |-> (&serializerOnA[4:0]))
    else $error("serializer clocked above a gap");

  a_mode_follow: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !sys_rst) |=> extraLaneMode == $past(link_mode_select))
    else $error("extra lane mode not following link mode");

  a_test_follow: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !sys_rst) |=> extraLaneTest == $past(link_test_pattern_select))
    else $error("extra lane test pattern not following link setting");

  // Refused write to link B leaves its register unchanged
  a_refused_link_b: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && regWrStb && link_encoder_enable && regAddr == `XL_OFF_LINK_B)
      |=> $stable(extra_lane_reg_link_b))
    else $error("link B register changed while encoder enabled");

  // Refusal flag pulses only after a strobe with the encoder on
  a_refused_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !sys_rst)
      |=> writeRefused == ($past(regWrStb) && $past(link_encoder_enable)))
    else $error("write refusal flag wrong");

  // Read data carries the addressed register in the cycle after the strobe
  a_rd_link_a: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && regRdStb && regAddr == `XL_OFF_LINK_A)
      |=> regRdData == $past(extra_lane_reg_link_a))
    else $error("link A read data wrong");

  a_rd_link_b: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && regRdStb && regAddr == `XL_OFF_LINK_B)
      |=> regRdData == $past(extra_lane_reg_link_b))
    else $error("link B read data wrong");

  // Outside a read cycle the read port shows zero
  a_rd_data_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (accState != ACC_READ) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");

  // Clock enable low holds both lane clock outputs, the link A serializers and the read port
  a_freeze_lanes: assert property (@(posedge clk) disable iff (sys_rst)
    !clkEn |=> ($stable(laneClockOnA) && $stable(serializerOnA)
      && $stable(laneClockOnB) && $stable(regRdData)))
    else $error("outputs moved while clock enable low");

  // Power-down of link B blocks all of its lanes
  sequence s_pd_hold_b;
    channel_power_down[1] && clkEn;
  endsequence
  a_power_down_b: assert property (@(posedge clk) disable iff (sys_rst)
    s_pd_hold_b |=> (laneClockOnB == '0 && serializerOnB == '0))
    else $error("lane active on powered-down link B");

  a_lane_clock_b: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !channel_power_down[1] && extra_lane_reg_link_b[7])
      |=> laneClockOnB[7])
    else $error("extra lane clock missing on link B");

  // Every extra lane and its serializer bit set: all serializers run
  a_ser_extra_on: assert property (@(posedge clk) disable iff (sys_rst)
    (clkEn && !channel_power_down[0] && modeLanesA[0] && (&extra_lane_reg_link_a))
      |=> (&serializerOnA))
    else $error("extra serializer not powered");

  a_ser_contig_b: assert property (@(posedge clk) disable iff (sys_rst)
    serializerOnB[7] |-> (&serializerOnB[6:0]))
    else $error("link B serializer clocked above a gap");
endmodule // serial_extra_lane_enable

// ### pkg/xlane_defines.svh
// Purpose: Offsets, field positions and reset values of the extra-lane bank
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes:   Definitions only
`ifndef XLANE_DEFINES_SVH
`define XLANE_DEFINES_SVH
`define XL_ADDR_W        10
`define XL_OFF_LINK_A    10'h20A
`define XL_OFF_LINK_B    10'h20B
`define XL_RESET_VAL     8'h00
`define XL_SER_BIT       0
`define XL_LANE_LSB      1
`define XL_LANE_MSB      7
`define XL_MODE_W        5
`define XL_TEST_W        4
`endif

// ### pkg/xlane_pkg.sv
// Purpose: Types shared by the extra-lane bank
// Assumes: Nothing beyond the defines header
// Notes:   Access state of the register port
package xlane_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b11
  } acc_state_t;
endpackage

// ### design/lane_gate.sv
// Purpose: Per-link lane enable decode for one link
// Assumes: Lane 0 is used whenever the link's channel is up
// Notes:   Registered outputs
`timescale 1ns/10ps
`include "xlane_defines.svh"
module lane_gate #(
  parameter int LANES = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic [7:0]       regValue,
  input  wire logic [LANES-1:0] modeLanes,
  input  wire logic             channelPowerDown,
  output logic      [LANES-1:0] laneClockOn,
  output logic      [LANES-1:0] serializerOn
);
  // The register holds seven extra-lane bits, so at most eight lanes fit
  if (LANES < 2 || LANES > 8) begin : g_lanes_check
    $error("LANES must be 2 to 8");
  end

  logic [LANES-1:0] next_clk;
  logic [LANES-1:0] next_ser;
  logic [LANES-1:0] ready;

  // Merge mode lanes with extra lanes, blocked by channel power-down
  always_comb begin
    next_clk = modeLanes;
    next_ser = modeLanes;
    for (int n = 1; n < LANES; n++) begin
      next_clk[n] = modeLanes[n] | regValue[n];
      next_ser[n] = modeLanes[n] | (regValue[n] & regValue[`XL_SER_BIT]);
    end
    if (channelPowerDown) begin
      next_clk = '0;
      next_ser = '0;
    end
    // Serializer n clocked only if lanes 0..n-1 enabled
    ready[0] = next_ser[0];
    for (int n = 1; n < LANES; n++) begin
      ready[n] = next_ser[n] & ready[n-1];
    end
  end

  // Register the lane enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      laneClockOn  <= '0;
      serializerOn <= '0;
    end else if (clkEn) begin
      laneClockOn  <= next_clk;
      serializerOn <= ready;
    end
  end
endmodule // lane_gate

// ### verif/lane_receiver.sv
// Purpose: Far-side lane receiver model for one link
// Assumes: Lanes are only usable from lane 0 upward
// Notes:   Reports how many contiguous lanes carry data
`timescale 1ns/10ps
module lane_receiver (
  input  wire logic       clk,
  input  wire logic [7:0] serializerOn,
  output logic      [3:0] rxLanes
);
  // Length of the unbroken lane chain from lane 0; a gap ends the usable group
  function automatic logic [3:0] chainLen(logic [7:0] s);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (s[i] && n == 4'(i)) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  // Receiver takes the lane count once per clock
  always_ff @(posedge clk) begin
    rxLanes <= chainLen(serializerOn);
  end
endmodule // lane_receiver

// ### verif/serial_extra_lane_enable_test.sv
// Purpose: Self-checking bench of the extra-lane register bank
// Assumes: Lane outputs settle two cycles after a write
// Notes:   Random register values, masks and power-down with corner cases
`timescale 1ns/10ps
`include "xlane_defines.svh"
module serial_extra_lane_enable_test;
  logic       clk = 1'b0, sysRst = 1'b1, clkEn = 1'b1, wrStb = 1'b0, rdStb = 1'b0, encEn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wrData = 8'h00, modeA = 8'h01, modeB = 8'h01, rdData, clkA, serA, clkB, serB;
  logic [4:0] mode = 5'h00, modeOut;
  logic [3:0] test = 4'h0, testOut, rxLanes;
  logic [1:0] pd = 2'b00;
  logic       refused;
  int         fails = 0, checksDone = 0, cyc = 0;
  always #50 clk = ~clk;
  serial_extra_lane_enable serial_extra_lane_enable_inst (.clk(clk), .sys_rst(sysRst),
    .clkEn(clkEn), .regAddr(addr), .regWrData(wrData), .regWrStb(wrStb), .regRdStb(rdStb),
    .regRdData(rdData), .link_encoder_enable(encEn), .link_mode_select(mode),
    .link_test_pattern_select(test), .modeLanesA(modeA), .modeLanesB(modeB),
    .channel_power_down(pd), .laneClockOnA(clkA), .serializerOnA(serA), .laneClockOnB(clkB),
    .serializerOnB(serB), .extraLaneMode(modeOut), .extraLaneTest(testOut),
    .writeRefused(refused));
  lane_receiver lane_receiver_inst (.clk(clk), .serializerOn(serA), .rxLanes(rxLanes));
  // Expected lane clocks: mode lanes plus register lanes, none when powered down
  function automatic logic [7:0] expClk(logic [7:0] r, logic [7:0] m, logic p);
    return p ? 8'h00 : ({r[7:1], 1'b0} | m);
  endfunction
  // Expected serializers: each needs every lower lane running
  function automatic logic [7:0] expSer(logic [7:0] r, logic [7:0] m, logic p);
    logic [7:0] s;
    s = 8'h00;
    s[0] = m[0] & ~p;
    for (int i = 1; i < 8; i++) s[i] = s[i-1] & (m[i] | (r[i] & r[0]));
    return s;
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One-cycle write, then the refusal flag in the following cycle
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    {wrStb, addr, wrData} <= {1'b1, a, d};
    @(posedge clk);
    wrStb <= 1'b0;
    #1 check({7'h00, refused}, {7'h00, encEn});
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] exp);
    @(posedge clk);
    {rdStb, addr} <= {1'b1, a};
    @(posedge clk);
    rdStb <= 1'b0;
    #1 check(rdData, exp);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] regs [2];
    logic       side;
    void'($urandom(31811));
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    rd(`XL_OFF_LINK_A, `XL_RESET_VAL);
    rd(`XL_OFF_LINK_B, `XL_RESET_VAL);
    rd(10'h209, 8'h00);
    regs = '{8'h00, 8'h00};
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      side = (i < 2) ? i[0] : 1'($urandom);
      encEn <= 1'b0;
      {mode, test} <= {5'($urandom), 4'($urandom)};
      pd <= (i < 2) ? 2'b00 : 2'($urandom);
      modeA <= (i > 3) ? (8'($urandom) | 8'h01) : 8'h01;
      modeB <= (i > 3) ? 8'($urandom) : 8'h01;
      regs[side] = (i == 0) ? 8'hFF : (i == 1) ? 8'hFB : 8'($urandom);
      wr(side ? `XL_OFF_LINK_B : `XL_OFF_LINK_A, regs[side]);
      @(posedge clk);
      #1 check(clkA, expClk(regs[0], modeA, pd[0]));
      check(clkB, expClk(regs[1], modeB, pd[1]));
      check(serA, expSer(regs[0], modeA, pd[0]));
      check(serB, expSer(regs[1], modeB, pd[1]));
      check({modeOut, 3'h0}, {mode, 3'h0});
      check({testOut, 4'h0}, {test, 4'h0});
      @(posedge clk);
      #1 check({4'h0, rxLanes}, 8'($countones(expSer(regs[0], modeA, pd[0]))));
      rd(side ? `XL_OFF_LINK_B : `XL_OFF_LINK_A, regs[side]);
    end
    // Clock enable low: a write strobe must leave the register untouched
    @(posedge clk);
    clkEn <= 1'b0;
    wr(`XL_OFF_LINK_A, ~regs[0]);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(`XL_OFF_LINK_A, regs[0]);
    // Second reset in mid-run returns both registers to zero
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    regs = '{8'h00, 8'h00};
    rd(`XL_OFF_LINK_A, `XL_RESET_VAL);
    rd(`XL_OFF_LINK_B, `XL_RESET_VAL);
    check(clkA, expClk(regs[0], modeA, pd[0]));
    check(serB, expSer(regs[1], modeB, pd[1]));
    // Encoder running: writes to either link are refused
    @(posedge clk);
    encEn <= 1'b1;
    wr(`XL_OFF_LINK_A, ~regs[0]);
    rd(`XL_OFF_LINK_A, regs[0]);
    wr(`XL_OFF_LINK_B, ~regs[1]);
    rd(`XL_OFF_LINK_B, regs[1]);
    tally_and_finish();
  end
endmodule // serial_extra_lane_enable_test
